// file: hw/obt_pkg.sv
// Constants and carrier types for the octal registered bus transceiver.
// Assumes one 40 MHz system clock; bus pins and capture clocks are synchronous to it.
//
// Operation
// RULE1: Each capture clock rising edge loads its bus into its register, regardless of controls.
// RULE2: Select low passes live opposite-bus data; select high passes the stored register.
// RULE3: B driven only when its enable is high; A only when its enable is low.
// RULE4: B enabled, A-to-B select low: B follows the live A bus.
// RULE5: B enabled, A-to-B select high: B shows the A-side register.
// RULE6: A enabled, B-to-A select low: A follows the live B bus.
// RULE7: A enabled, B-to-A select high: A shows the B-side register.
// RULE8: Both enabled, both selects high: both ports show the opposite registers together.
// RULE9: Data non-inverted; A only pulls low or releases; B drives high, low or floats.
// RULE10: Both enabled, both selects low: each port reinforces its input, holding the bus.
// RULE11: Only B enabled, both clocks rising: A value lands in both registers.
// RULE12: Only A enabled, both clocks rising: B value lands in both registers.
// RULE13: Controller may clock both together only with select low; otherwise staggers them.
// RULE14: Changing a select never glitches the driven outputs.
// RULE15: All eight channels identical and share controls; registers have no reset.
package obt_pkg;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int   OBT_WIDTH          = 8;
    localparam logic OBT_OE_RST         = 1'b0;
    localparam logic OBT_CLK_PREV_RST   = 1'b1;
    localparam logic OBT_A_PULL_LEVEL   = 1'b0;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic b_drive_en;
        logic a_drive_en_low;
        logic a_to_b_sel;
        logic b_to_a_sel;
    } obt_ctrl_t;

    typedef struct packed {
        logic [OBT_WIDTH-1:0] data;
        logic [OBT_WIDTH-1:0] oe;
    } obt_pin_t;

endpackage : obt_pkg

// file: hw/obt_transceiver.sv
// Octal registered bus transceiver: two capture registers, live/stored muxes, pin drivers.
// Assumes all inputs are synchronous to CLK; the bench resolves the A and B wires from the
// output and enable signals and feeds the resolved levels back on the input pins.
module obt_transceiver
    import obt_pkg::*;
#(
    parameter int WIDTH = OBT_WIDTH
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             A_CAPTURE_CLOCK,
    input  wire logic             B_CAPTURE_CLOCK,
    input  wire logic             B_PORT_DRIVE_ENABLE,
    input  wire logic             A_PORT_DRIVE_ENABLE_LOW,
    input  wire logic             A_TO_B_SOURCE_SELECT,
    input  wire logic             B_TO_A_SOURCE_SELECT,
    input  wire logic [WIDTH-1:0] A_SIDE_BUS_I,
    output logic      [WIDTH-1:0] A_SIDE_BUS_O,
    output logic      [WIDTH-1:0] A_SIDE_BUS_OE,
    input  wire logic [WIDTH-1:0] B_SIDE_BUS_I,
    output logic      [WIDTH-1:0] B_SIDE_BUS_O,
    output logic      [WIDTH-1:0] B_SIDE_BUS_OE
);

    // ****************************************************************
    // Capture clock edge detection
    // ****************************************************************
    obt_ctrl_t        ctrl;
    logic             a_clk_prev_reg;
    logic             a_clk_prev_next;
    logic             b_clk_prev_reg;
    logic             b_clk_prev_next;
    logic             a_edge;
    logic             b_edge;

    assign ctrl = '{b_drive_en:     B_PORT_DRIVE_ENABLE,
                    a_drive_en_low: A_PORT_DRIVE_ENABLE_LOW,
                    a_to_b_sel:     A_TO_B_SOURCE_SELECT,
                    b_to_a_sel:     B_TO_A_SOURCE_SELECT};

    // Previous level resets high so a clock held high through reset is not seen as an edge
    always_comb begin
        a_clk_prev_next = A_CAPTURE_CLOCK;
        b_clk_prev_next = B_CAPTURE_CLOCK;
        a_edge          = A_CAPTURE_CLOCK & ~a_clk_prev_reg;
        b_edge          = B_CAPTURE_CLOCK & ~b_clk_prev_reg;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            a_clk_prev_reg <= OBT_CLK_PREV_RST;
            b_clk_prev_reg <= OBT_CLK_PREV_RST;
        end else begin
            a_clk_prev_reg <= a_clk_prev_next;
            b_clk_prev_reg <= b_clk_prev_next;
        end
    end

    // ****************************************************************
    // Storage registers
    // ****************************************************************
    logic [WIDTH-1:0] a_store_reg;
    logic [WIDTH-1:0] a_store_next;
    logic [WIDTH-1:0] b_store_reg;
    logic [WIDTH-1:0] b_store_next;

    // Loads ignore selects and enables; with a port driven, the resolved wire carries the
    // opposite bus back in, so both registers fill from one bus
    always_comb begin
        a_store_next = a_edge ? A_SIDE_BUS_I : a_store_reg; // RULE1 RULE12
        b_store_next = b_edge ? B_SIDE_BUS_I : b_store_reg; // RULE1 RULE11
    end

    // No reset on purpose: contents are undefined until the first capture edge
    always_ff @(posedge CLK) begin
        a_store_reg <= a_store_next; // RULE15
        b_store_reg <= b_store_next;
    end

    // ****************************************************************
    // Source muxes and pin drivers, one identical slice per bit
    // ****************************************************************
    obt_pin_t a_pin_reg;
    obt_pin_t a_pin_next;
    obt_pin_t b_pin_reg;
    obt_pin_t b_pin_next;

    // Per-bit source choice lands on nets so that each slice has its own single driver
    wire [WIDTH-1:0] to_b_vec;
    wire [WIDTH-1:0] to_a_vec;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit // RULE15
            // A slice sees only its own bit; no bit of one channel leaks into another
            assign to_b_vec[gi] = ctrl.a_to_b_sel ? a_store_reg[gi] : A_SIDE_BUS_I[gi]; // RULE2 RULE4 RULE5
            assign to_a_vec[gi] = ctrl.b_to_a_sel ? b_store_reg[gi] : B_SIDE_BUS_I[gi]; // RULE2 RULE6 RULE7

            // Open drain: a slice never asks for a high level on the A side
            bit_a_low_a: assert property (@(posedge CLK) disable iff (RST) // RULE9
                A_SIDE_BUS_OE[gi] |-> (A_SIDE_BUS_O[gi] == 1'b0))
                else $error("A slice drove a high level while pulling");
        end
    endgenerate

    // One process builds both pin words; the A side pulls only where the source bit is low
    always_comb begin
        b_pin_next.data = to_b_vec; // RULE9
        b_pin_next.oe   = {WIDTH{ctrl.b_drive_en}}; // RULE3 RULE8 RULE10
        a_pin_next.data = {WIDTH{OBT_A_PULL_LEVEL}};
        a_pin_next.oe   = {WIDTH{~ctrl.a_drive_en_low}} & ~to_a_vec; // RULE3 RULE9 RULE8 RULE10
    end

    // Registering the pins removes any decode glitch when a select flips, at one cycle of latency
    always_ff @(posedge CLK) begin
        if (RST) begin
            a_pin_reg <= '{data: {WIDTH{OBT_A_PULL_LEVEL}}, oe: {WIDTH{OBT_OE_RST}}};
            b_pin_reg <= '{data: {WIDTH{OBT_A_PULL_LEVEL}}, oe: {WIDTH{OBT_OE_RST}}};
        end else begin
            a_pin_reg <= a_pin_next; // RULE14
            b_pin_reg <= b_pin_next; // RULE14
        end
    end

    assign A_SIDE_BUS_O  = a_pin_reg.data;
    assign A_SIDE_BUS_OE = a_pin_reg.oe;
    assign B_SIDE_BUS_O  = b_pin_reg.data;
    assign B_SIDE_BUS_OE = b_pin_reg.oe;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    load_a_reg_a: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (A_CAPTURE_CLOCK && !a_clk_prev_reg) |=> (a_store_reg == $past(A_SIDE_BUS_I)))
        else $error("A-side register missed a capture edge");

    load_b_reg_a: assert property (@(posedge CLK) disable iff (RST) // RULE1
        (B_CAPTURE_CLOCK && !b_clk_prev_reg) ##1 !(B_CAPTURE_CLOCK && !b_clk_prev_reg)
        |=> $stable(b_store_reg) && (b_store_reg == $past(B_SIDE_BUS_I, 2)))
        else $error("B-side register missed a capture edge or changed without one");

    b_enable_a: assert property (@(posedge CLK) disable iff (RST) // RULE3
        ##1 (B_SIDE_BUS_OE == {WIDTH{$past(B_PORT_DRIVE_ENABLE)}}))
        else $error("B port drive does not follow its enable");

    a_isolate_a: assert property (@(posedge CLK) disable iff (RST) // RULE3
        A_PORT_DRIVE_ENABLE_LOW |=> (A_SIDE_BUS_OE == '0))
        else $error("A port pulled while disabled");

    b_live_a: assert property (@(posedge CLK) disable iff (RST) // RULE4
        (B_PORT_DRIVE_ENABLE && !A_TO_B_SOURCE_SELECT) |=> (B_SIDE_BUS_O == $past(A_SIDE_BUS_I)))
        else $error("B port not showing live A data");

    b_stored_a: assert property (@(posedge CLK) disable iff (RST) // RULE5
        (B_PORT_DRIVE_ENABLE && A_TO_B_SOURCE_SELECT) |=> (B_SIDE_BUS_O == $past(a_store_reg)))
        else $error("B port not showing A-side register");

    a_live_a: assert property (@(posedge CLK) disable iff (RST) // RULE6
        (!A_PORT_DRIVE_ENABLE_LOW && !B_TO_A_SOURCE_SELECT) |=> (A_SIDE_BUS_OE == ~$past(B_SIDE_BUS_I)))
        else $error("A port not showing live B data");

    a_stored_a: assert property (@(posedge CLK) disable iff (RST) // RULE7
        (!A_PORT_DRIVE_ENABLE_LOW && B_TO_A_SOURCE_SELECT) |=> (A_SIDE_BUS_OE == ~$past(b_store_reg)))
        else $error("A port not showing B-side register");

    both_stored_a: assert property (@(posedge CLK) disable iff (RST) // RULE8
        (B_PORT_DRIVE_ENABLE && !A_PORT_DRIVE_ENABLE_LOW && A_TO_B_SOURCE_SELECT && B_TO_A_SOURCE_SELECT)
        |=> (B_SIDE_BUS_O == $past(a_store_reg)) && (A_SIDE_BUS_OE == ~$past(b_store_reg)))
        else $error("Simultaneous stored transfer broken");

    a_open_drain_a: assert property (@(posedge CLK) disable iff (RST) // RULE9
        ##1 (A_SIDE_BUS_O == '0))
        else $error("A port drove a high level");

    // ****************************************************************
    // Loopback and dual loads
    // ****************************************************************
    // Both ports live: each side hands the other its own input back, one cycle later
    loop_hold_a: assert property (@(posedge CLK) disable iff (RST) // RULE10
        (B_PORT_DRIVE_ENABLE && !A_PORT_DRIVE_ENABLE_LOW && !A_TO_B_SOURCE_SELECT && !B_TO_A_SOURCE_SELECT)
        |=> (B_SIDE_BUS_O == $past(A_SIDE_BUS_I)) && (A_SIDE_BUS_OE == ~$past(B_SIDE_BUS_I)))
        else $error("Loopback does not reinforce the bus");

    // Depends on the surrounding wires resolving the driven B port back onto its input
    dual_b_load_a: assert property (@(posedge CLK) disable iff (RST) // RULE11
        (A_CAPTURE_CLOCK && !a_clk_prev_reg && B_CAPTURE_CLOCK && !b_clk_prev_reg
         && B_PORT_DRIVE_ENABLE && A_PORT_DRIVE_ENABLE_LOW && !A_TO_B_SOURCE_SELECT
         && $past(B_PORT_DRIVE_ENABLE) && $past(!A_TO_B_SOURCE_SELECT)
         && $stable(A_SIDE_BUS_I) && !$past(RST))
        |=> (a_store_reg == b_store_reg))
        else $error("A bus value did not reach both registers");

    // Depends on no other party sinking the A wires while the load is taken
    dual_a_load_a: assert property (@(posedge CLK) disable iff (RST) // RULE12
        (A_CAPTURE_CLOCK && !a_clk_prev_reg && B_CAPTURE_CLOCK && !b_clk_prev_reg
         && !A_PORT_DRIVE_ENABLE_LOW && !B_PORT_DRIVE_ENABLE && !B_TO_A_SOURCE_SELECT
         && $past(!A_PORT_DRIVE_ENABLE_LOW) && $past(!B_TO_A_SOURCE_SELECT)
         && $stable(B_SIDE_BUS_I) && !$past(RST))
        |=> (a_store_reg == b_store_reg))
        else $error("B bus value did not reach both registers");

    // ****************************************************************
    // Select switching and channel uniformity
    // ****************************************************************
    // With live and stored data equal, flipping the select must leave the pins untouched
    b_glitch_a: assert property (@(posedge CLK) disable iff (RST) // RULE14
        (B_PORT_DRIVE_ENABLE && $stable(B_PORT_DRIVE_ENABLE) && (a_store_reg == A_SIDE_BUS_I)
         && $stable(A_SIDE_BUS_I) && $stable(a_store_reg) && !$past(RST))
        |=> $stable(B_SIDE_BUS_O))
        else $error("B port moved although live and stored data agree");

    a_glitch_a: assert property (@(posedge CLK) disable iff (RST) // RULE14
        (!A_PORT_DRIVE_ENABLE_LOW && $stable(A_PORT_DRIVE_ENABLE_LOW) && (b_store_reg == B_SIDE_BUS_I)
         && $stable(B_SIDE_BUS_I) && $stable(b_store_reg) && !$past(RST))
        |=> $stable(A_SIDE_BUS_OE))
        else $error("A port moved although live and stored data agree");

    // All channels share one enable, so the B drive word is all ones or all zeros
    b_uniform_a: assert property (@(posedge CLK) disable iff (RST) // RULE15
        ##1 ((B_SIDE_BUS_OE == {WIDTH{1'b0}}) || (B_SIDE_BUS_OE == {WIDTH{1'b1}})))
        else $error("B channels disagree on their drive enable");

    // ****************************************************************
    // Cover points
    // ****************************************************************
    loopback_c: cover property (@(posedge CLK) disable iff (RST)
        B_PORT_DRIVE_ENABLE && !A_PORT_DRIVE_ENABLE_LOW && !A_TO_B_SOURCE_SELECT && !B_TO_A_SOURCE_SELECT);
    dual_load_c: cover property (@(posedge CLK) disable iff (RST)
        a_edge && b_edge && B_PORT_DRIVE_ENABLE);
    sel_flip_c: cover property (@(posedge CLK) disable iff (RST)
        B_PORT_DRIVE_ENABLE && $changed(A_TO_B_SOURCE_SELECT));
    a_dual_load_c: cover property (@(posedge CLK) disable iff (RST)
        a_edge && b_edge && !A_PORT_DRIVE_ENABLE_LOW);
    both_stored_c: cover property (@(posedge CLK) disable iff (RST)
        B_PORT_DRIVE_ENABLE && !A_PORT_DRIVE_ENABLE_LOW && A_TO_B_SOURCE_SELECT && B_TO_A_SOURCE_SELECT);

endmodule : obt_transceiver

// file: dv/obt_bus_partner.sv
// Far-side logic on both buses: A is open drain with a pull-up, B is three-state.
// Assumes the bench changes its drive requests just after CLK rising edges.
module obt_bus_partner
    import obt_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 a_pull_en,
    input  wire logic [OBT_WIDTH-1:0] a_val,
    input  wire logic                 b_drv_en,
    input  wire logic [OBT_WIDTH-1:0] b_val,
    input  wire obt_pin_t             dut_a,
    input  wire obt_pin_t             dut_b,
    output logic      [OBT_WIDTH-1:0] a_wire,
    output logic      [OBT_WIDTH-1:0] b_wire
);
    logic [OBT_WIDTH-1:0] b_last_reg;
    // Pull-up wins unless some party sinks the bit
    assign a_wire = ~(dut_a.oe | ({OBT_WIDTH{a_pull_en}} & ~a_val));
    // A floating B bit flips every cycle so a stale level never passes for a held one
    assign b_wire = (dut_b.oe & dut_b.data) | (~dut_b.oe & (b_drv_en ? b_val : ~b_last_reg));
    always_ff @(posedge clk) begin
        b_last_reg <= b_wire;
    end
endmodule : obt_bus_partner

// file: dv/test_obt_transceiver.sv
// Self-checking bench for the octal registered bus transceiver.
// Assumes the partner model resolves both wires; checks run at the falling edge.
module test_obt_transceiver import obt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0, rst = 1'b1, a_clk = 1'b0, b_clk = 1'b0;
    logic                 a_pull = 1'b0, b_drv = 1'b1;
    logic [OBT_WIDTH-1:0] a_val = 8'hff, b_val = 8'h00, a_wire, b_wire;
    obt_ctrl_t            ctl = obt_ctrl_t'(4'h4);
    wire obt_pin_t        pa, pb;
    int                   error_cnt = 0, total_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    obt_transceiver dut_u (.CLK(clk), .RST(rst), .A_CAPTURE_CLOCK(a_clk), .B_CAPTURE_CLOCK(b_clk),
        .B_PORT_DRIVE_ENABLE(ctl.b_drive_en), .A_PORT_DRIVE_ENABLE_LOW(ctl.a_drive_en_low),
        .A_TO_B_SOURCE_SELECT(ctl.a_to_b_sel), .B_TO_A_SOURCE_SELECT(ctl.b_to_a_sel),
        .A_SIDE_BUS_I(a_wire), .A_SIDE_BUS_O(pa.data), .A_SIDE_BUS_OE(pa.oe),
        .B_SIDE_BUS_I(b_wire), .B_SIDE_BUS_O(pb.data), .B_SIDE_BUS_OE(pb.oe));
    obt_bus_partner partner_u (.clk(clk), .a_pull_en(a_pull), .a_val(a_val), .b_drv_en(b_drv),
        .b_val(b_val), .dut_a(pa), .dut_b(pb), .a_wire(a_wire), .b_wire(b_wire));
    task automatic chk(input string what, input logic [OBT_WIDTH-1:0] exp, input logic [OBT_WIDTH-1:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One cycle of latency plus a margin, then sample away from the edge
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // Capture clocks stay low one sample between highs so each pulse is one edge
    task automatic pulse(input logic on_a);
        @(posedge clk) {a_clk, b_clk} <= {on_a, ~on_a};
        @(posedge clk) {a_clk, b_clk} <= 2'h0;
    endtask : pulse
    // Both capture clocks together; only legal while the driving side selects live data
    task automatic pulse_both;
        @(posedge clk) {a_clk, b_clk} <= 2'h3;
        @(posedge clk) {a_clk, b_clk} <= 2'h0;
    endtask : pulse_both
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_live_ab;
        @(posedge clk) ctl <= obt_ctrl_t'(4'hc);
        {b_drv, a_pull, a_val} <= {2'h1, 8'h5a};
        settle;
        chk("b_out", 8'h5a, pb.data);
        chk("b_oe", 8'hff, pb.oe);
        chk("a_oe", 8'h00, pa.oe);
        chk("b_wire", 8'h5a, b_wire);
    endtask : t_live_ab
    task automatic t_store_ab;
        @(posedge clk) a_val <= 8'h3c;
        pulse(1'b1);
        @(posedge clk) {a_val, ctl.a_to_b_sel} <= {8'hc3, 1'b1};
        settle;
        chk("b_stored", 8'h3c, pb.data);
        @(posedge clk) ctl.a_to_b_sel <= 1'b0;
        settle;
        chk("b_live", 8'hc3, pb.data);
    endtask : t_store_ab
    task automatic t_ba;
        @(posedge clk) ctl <= obt_ctrl_t'(4'h0);
        {b_drv, b_val, a_pull} <= {1'b1, 8'hf0, 1'b0};
        settle;
        chk("a_oe_live", 8'h0f, pa.oe);
        chk("a_out", 8'h00, pa.data);
        chk("b_oe_off", 8'h00, pb.oe);
        pulse(1'b0);
        @(posedge clk) {b_val, ctl.b_to_a_sel} <= {8'h81, 1'b1};
        settle;
        chk("a_stored", 8'hf0, a_wire);
    endtask : t_ba
    task automatic t_both_stored;
        @(posedge clk) {ctl, b_drv} <= {4'hb, 1'b0};
        settle;
        chk("b_reg", 8'h3c, pb.data);
        chk("a_reg", 8'hf0, a_wire);
    endtask : t_both_stored
    // Enable A after B already follows it, else the open-drain loop can latch stray lows
    task automatic t_loop;
        @(posedge clk) {ctl, a_pull, a_val} <= {4'hc, 1'b1, 8'h96};
        settle;
        @(posedge clk) ctl.a_drive_en_low <= 1'b0;
        settle;
        @(posedge clk) a_pull <= 1'b0;
        settle;
        chk("a_hold", 8'h96, a_wire);
        chk("b_hold", 8'h96, b_wire);
        @(posedge clk) ctl <= obt_ctrl_t'(4'h7);
        settle;
        chk("iso_oe", 8'h00, pa.oe | pb.oe);
    endtask : t_loop
    task automatic t_dual;
        @(posedge clk) {ctl, a_pull, a_val, b_drv} <= {4'hc, 1'b1, 8'ha5, 1'b0};
        settle;
        pulse_both;
        @(posedge clk) ctl.a_to_b_sel <= 1'b1;
        settle;
        chk("b_after_flip", 8'ha5, pb.data);
        @(posedge clk) {ctl, a_pull, a_val} <= {4'hb, 1'b0, 8'hff};
        settle;
        chk("dual_a_reg", 8'ha5, pb.data);
        chk("dual_b_reg", 8'ha5, a_wire);
        @(posedge clk) {ctl, b_drv, b_val} <= {4'h0, 1'b1, 8'h69};
        settle;
        pulse_both;
        @(posedge clk) {ctl, b_drv} <= {4'hb, 1'b0};
        settle;
        chk("dual2_a_reg", 8'h69, pb.data);
        chk("dual2_b_reg", 8'h69, a_wire);
    endtask : t_dual
    task automatic complete_run;
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_live_ab;
        t_store_ab;
        t_ba;
        t_both_stored;
        t_loop;
        t_dual;
        complete_run;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            error_cnt++;
            complete_run;
        end
    end
endmodule : test_obt_transceiver
